// File: oss_source_select.sv
`timescale 1ns/1ns
`default_nettype none
`include "oss_consts.svh"
// Function
// (RULE_01) power-on reset takes start source and mode from configuration fields
// (RULE_02) erased configuration starts on fast RC through its postscaler
// (RULE_03) external clock range defaults above 8 MHz, applied in external clock mode
// (RULE_04) source switching enabled only when upper switch/monitor bit is zero
// (RULE_05) fail-safe monitor active only when switch/monitor field is 00
// (RULE_06) select and primary fields decode into eleven clock modes
// (RULE_07) read-only current source field shows the source in use
// (RULE_08) writable new source field resets to the initial source configuration
// (RULE_09) instruction clock is the selected system clock divided by two
// (RULE_10) oscillator output pin may carry the instruction clock per configuration
// (RULE_11) multiplier offered only for primary and fast RC sources
// (RULE_12) fast RC frequency reducible by a programmable divider
// (RULE_13) multiplier lock bit clears at valid switch and in non-multiplier modes
// (RULE_14) secondary drive bit ignored when secondary runs from digital input
// (RULE_15) software only sets selection lock; clock fail set by hardware, cleared by software
// (RULE_16) secondary circuit power chosen by configuration bit
// (RULE_17) switch enable starts switch, hardware clears it, held zero when disabled
// (RULE_18) detected clock failure sets the clock fail bit
// (RULE_19) monitor on and lock set refuse clock and multiplier changes
// (RULE_20) wait ten new-source cycles, then copy new into current source
// (RULE_21) system clock held low across the changeover, no runt pulses
module oss_source_select #(
  parameter int SWITCH_TICKS = `OSS_SWITCH_TICKS
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // configuration and oscillator status
  input wire oss_pkg::oss_cfg_s cfg,
  input wire oss_pkg::oss_ticks_s ticks,
  input wire logic pll_locked,
  input wire logic fail_detect,
  // clock outputs
  output logic sys_tick,
  output logic fcy,
  output logic oscillator_output_pin_o,
  output logic oscillator_output_pin_oe_n,
  // oscillator controls
  output oss_pkg::oss_mode_e mode,
  output logic pll_enable,
  output logic secondary_osc_enable,
  output logic secondary_high_power,
  output logic [1:0] ext_range,
  output logic fail_safe_monitor
);
  import oss_pkg::*;

  initial begin
    if (SWITCH_TICKS < 1 || SWITCH_TICKS > 15) $error("SWITCH_TICKS out of range");
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_pll(input logic [2:0] s);
    is_pll = (s == `OSS_SRC_PPLL) || (s == `OSS_SRC_FPLL); // RULE_11
  endfunction

  function automatic logic raw_tick(input logic [2:0] s, input oss_ticks_s t);
    case (s)
      `OSS_SRC_FAST_RC_WITH_POSTSCALER, `OSS_SRC_FRC: raw_tick = t.fast_rc;
      `OSS_SRC_LPFRC: raw_tick = t.lowpower_fast_rc;
      `OSS_SRC_LOWPOWER_RC_SOURCE: raw_tick = t.lowpower_rc;
      `OSS_SRC_SECONDARY_SOURCE: raw_tick = t.secondary;
      `OSS_SRC_PRI: raw_tick = t.primary;
      default: raw_tick = t.multiplier; // RULE_11
    endcase
  endfunction

  function automatic oss_mode_e decode(input logic [2:0] s, input logic [1:0] pm);
    case (s) // RULE_06
      `OSS_SRC_FAST_RC_WITH_POSTSCALER: decode = OSS_M_FAST_RC_WITH_POSTSCALER;
      `OSS_SRC_LPFRC: decode = OSS_M_LOWPOWER_FAST_RC_POSTSCALED;
      `OSS_SRC_LOWPOWER_RC_SOURCE: decode = OSS_M_LOWPOWER_RC_SOURCE;
      `OSS_SRC_SECONDARY_SOURCE: decode = OSS_M_SECONDARY_SOURCE;
      `OSS_SRC_PPLL: decode = (pm == `OSS_PM_EC) ? OSS_M_EXTERNAL_CLOCK_MULTIPLIED_EC : OSS_M_HIGHSPEED_CRYSTAL_MULTIPLIED_HS;
      `OSS_SRC_PRI: begin
        case (pm)
          `OSS_PM_HS: decode = OSS_M_HS;
          `OSS_PM_XT: decode = OSS_M_XT;
          `OSS_PM_EC: decode = OSS_M_EC;
          default: decode = OSS_M_BAD;
        endcase
      end
      `OSS_SRC_FPLL: decode = OSS_M_FAST_RC_WITH_MULTIPLIER;
      default: decode = OSS_M_FRC;
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************
  oss_cfg_s cfg_r;
  oss_state_e state_r;
  logic [2:0] current_source_field_r, new_source_field_r, psc_sel_r;
  logic lock_r, pll_lock_r, cf_r, drv_r, sen_r, switch_enable_bit_r, fcy_r, sys_tick_r;
  logic [3:0] tick_cnt_r;
  logic [7:0] psc_cnt_r;
  logic [31:0] prdata_r;
  logic sw_en, fail_safe_monitor_en, locked, wr, wr_ctrl, wr_div, start, raw, psc_on, psc_hit;
  logic [7:0] psc_top;

  assign sw_en = ~cfg_r.switch_monitor_config[1]; // RULE_04
  assign fail_safe_monitor_en = cfg_r.switch_monitor_config == `OSS_SWM_ON; // RULE_05
  assign locked = fail_safe_monitor_en & lock_r; // RULE_19
  assign wr = psel & penable & pwrite & ce;
  assign wr_ctrl = wr & (paddr == `OSS_ADDR_CTRL);
  assign wr_div = wr & (paddr == `OSS_ADDR_DIV);
  assign start = (state_r == OSS_IDLE) & switch_enable_bit_r & (new_source_field_r != current_source_field_r);

  // ****************************************
  // configuration capture
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cfg_r <= cfg; // RULE_01
    end
  end

  // ****************************************
  // control register fields
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      new_source_field_r <= cfg.initial_source_config; // RULE_08
      lock_r <= 1'b0;
      drv_r <= 1'b0;
      sen_r <= 1'b0;
      psc_sel_r <= `OSS_PSC_RST;
    end else if (wr_ctrl) begin
      if (pstrb[1] && !locked && state_r == OSS_IDLE) begin
        new_source_field_r <= pwdata[`OSS_F_NEW_SOURCE_FIELD]; // RULE_19
      end
      if (pstrb[0]) begin
        lock_r <= lock_r | (pwdata[`OSS_B_LOCK] & fail_safe_monitor_en); // RULE_15
        drv_r <= pwdata[`OSS_B_DRV];
        sen_r <= pwdata[`OSS_B_SEN];
      end
    end else if (wr_div && pstrb[0]) begin
      psc_sel_r <= pwdata[`OSS_F_PSC]; // RULE_12
    end
  end

  // clear on software zero, but a failure in the same cycle wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cf_r <= 1'b0;
    end else if (ce) begin
      if (fail_safe_monitor_en && fail_detect) begin
        cf_r <= 1'b1; // RULE_18
      end else if (start || (wr_ctrl && pstrb[0] && !pwdata[`OSS_B_CF])) begin
        cf_r <= 1'b0; // RULE_15
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      pll_lock_r <= 1'b0;
    end else if (ce) begin
      pll_lock_r <= (state_r == OSS_IDLE) && !start && is_pll(current_source_field_r) && pll_locked; // RULE_13
    end
  end

  // ****************************************
  // switch sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state_r <= OSS_IDLE;
      switch_enable_bit_r <= 1'b0;
      tick_cnt_r <= 4'h0;
      current_source_field_r <= cfg.initial_source_config; // RULE_02
    end else if (ce) begin
      case (state_r)
        OSS_IDLE: begin
          tick_cnt_r <= 4'h0;
          if (switch_enable_bit_r && new_source_field_r == current_source_field_r) begin
            switch_enable_bit_r <= 1'b0; // RULE_17
          end else if (start) begin
            state_r <= OSS_WAIT; // RULE_17
          end else if (wr_ctrl && pstrb[0] && pwdata[`OSS_B_SWEN] && sw_en && !locked) begin
            switch_enable_bit_r <= 1'b1; // RULE_17
          end
        end
        OSS_WAIT: begin
          // a multiplier target must be locked before its edges are trusted
          if (raw_tick(new_source_field_r, ticks) && (!is_pll(new_source_field_r) || pll_locked)) begin
            if (tick_cnt_r == 4'(SWITCH_TICKS - 1)) begin
              state_r <= OSS_SWAP; // RULE_20
            end
            tick_cnt_r <= tick_cnt_r + 4'h1;
          end
        end
        OSS_SWAP: begin
          current_source_field_r <= new_source_field_r; // RULE_20
          switch_enable_bit_r <= 1'b0; // RULE_17
          state_r <= OSS_IDLE;
        end
        default: begin
          state_r <= OSS_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // postscaler and system clock
  // ****************************************
  assign psc_on = (current_source_field_r == `OSS_SRC_FAST_RC_WITH_POSTSCALER) || (current_source_field_r == `OSS_SRC_LPFRC);
  always_comb begin
    case (psc_sel_r)
      3'h7: psc_top = 8'hFF;
      3'h6: psc_top = 8'h3F;
      3'h5: psc_top = 8'h1F;
      3'h4: psc_top = 8'h0F;
      3'h3: psc_top = 8'h07;
      3'h2: psc_top = 8'h03;
      3'h1: psc_top = 8'h01;
      default: psc_top = 8'h00;
    endcase
  end
  assign raw = raw_tick(current_source_field_r, ticks);
  assign psc_hit = !psc_on || psc_cnt_r >= psc_top; // RULE_12

  always_ff @(posedge clk) begin
    if (!rstn) begin
      psc_cnt_r <= 8'h00;
    end else if (ce && raw) begin
      psc_cnt_r <= psc_hit ? 8'h00 : psc_cnt_r + 8'h01;
    end
  end

  // changeover cycle gated low so old and new edges never merge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      sys_tick_r <= 1'b0;
    end else if (ce) begin
      sys_tick_r <= raw & psc_hit & (state_r != OSS_SWAP); // RULE_21
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      fcy_r <= 1'b0;
    end else if (ce && sys_tick_r) begin
      fcy_r <= ~fcy_r; // RULE_09
    end
  end

  // ****************************************
  // apb read path
  // ****************************************
  always_ff @(posedge clk) begin
    if (!rstn) begin
      prdata_r <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_r <= 32'h0000_0000;
      if (paddr == `OSS_ADDR_CTRL) begin
        prdata_r[15:0] <= `OSS_CTRL_RST_VIS;
        prdata_r[`OSS_F_CURRENT_SOURCE_FIELD] <= current_source_field_r; // RULE_07
        prdata_r[`OSS_F_NEW_SOURCE_FIELD] <= new_source_field_r;
        prdata_r[`OSS_B_LOCK] <= locked;
        prdata_r[`OSS_B_PLLOK] <= pll_lock_r;
        prdata_r[`OSS_B_CF] <= cf_r;
        prdata_r[`OSS_B_DRV] <= drv_r;
        prdata_r[`OSS_B_SEN] <= sen_r;
        prdata_r[`OSS_B_SWEN] <= switch_enable_bit_r;
      end else if (paddr == `OSS_ADDR_DIV) begin
        prdata_r[`OSS_F_PSC] <= psc_sel_r;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel & penable & (paddr != `OSS_ADDR_CTRL) & (paddr != `OSS_ADDR_DIV);

  // ****************************************
  // pins and controls
  // ****************************************
  assign sys_tick = sys_tick_r;
  assign fcy = fcy_r;
  assign mode = decode(current_source_field_r, cfg_r.primary_mode_config); // RULE_06
  assign pll_enable = is_pll(current_source_field_r) | (state_r != OSS_IDLE && is_pll(new_source_field_r)); // RULE_11
  assign secondary_osc_enable = sen_r;
  // drive bit only matters for a crystal on the secondary pins
  assign secondary_high_power = cfg_r.secondary_power_config // RULE_16
    | (cfg_r.secondary_input_source_config & drv_r); // RULE_14
  assign ext_range = (mode == OSS_M_EC || mode == OSS_M_EXTERNAL_CLOCK_MULTIPLIED_EC) ?
    cfg_r.ext_clock_range_config : `OSS_EXT_RANGE_DFLT; // RULE_03
  assign fail_safe_monitor = fail_safe_monitor_en;
  assign oscillator_output_pin_o = fcy_r; // RULE_10
  assign oscillator_output_pin_oe_n = ~(cfg_r.osc_out_pin_function_config & // RULE_10
    (mode != OSS_M_HS) & (mode != OSS_M_XT) & (mode != OSS_M_HIGHSPEED_CRYSTAL_MULTIPLIED_HS));

  // ****************************************
  // checks
  // ****************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence swap_step;
    (state_r == OSS_SWAP) && ce;
  endsequence

  chk_switch_disabled: assert property (!sw_en |-> !switch_enable_bit_r) // RULE_04
    else $error("switch enable set while switching disabled");
  chk_monitor_off_cf: assert property (!fail_safe_monitor_en |-> !cf_r) // RULE_05
    else $error("clock fail set with monitor off");
  chk_fail_sets_cf: assert property (ce && fail_safe_monitor_en && fail_detect |=> cf_r) // RULE_18
    else $error("failure did not set clock fail");
  chk_pll_lock_mode: assert property (!is_pll(current_source_field_r) |-> !pll_lock_r) // RULE_13
    else $error("lock status high in non-multiplier mode");
  chk_swap_copies: assert property (swap_step |=> current_source_field_r == $past(new_source_field_r) && !switch_enable_bit_r) // RULE_20
    else $error("current source not copied at changeover");
  chk_locked_new_source_field: assert property (locked && state_r == OSS_IDLE |=> $stable(new_source_field_r)) // RULE_19
    else $error("new source changed while locked");
  chk_fcy_half: assert property (ce && sys_tick_r |=> fcy_r != $past(fcy_r)) // RULE_09
    else $error("instruction clock did not toggle");
  chk_swap_no_tick: assert property (swap_step |=> !sys_tick_r) // RULE_21
    else $error("system tick during changeover");
  chk_wait_ticks: assert property (swap_step |-> tick_cnt_r == 4'(SWITCH_TICKS)) // RULE_20
    else $error("changeover before ten source ticks");
  chk_reset_new_source_field: assert property ($rose(rstn) |-> new_source_field_r == current_source_field_r) // RULE_08
    else $error("new source not equal to initial source at reset");
endmodule // oss_source_select
`default_nettype wire

// File: oss_consts.svh
`ifndef OSS_CONSTS_SVH
`define OSS_CONSTS_SVH
// ****************************************
// register map
// ****************************************
`define OSS_ADDR_CTRL 12'h000
`define OSS_ADDR_DIV 12'h004
`define OSS_CTRL_RST_VIS 16'h0000
// ****************************************
// field positions of the control and divider registers
// ****************************************
`define OSS_F_CURRENT_SOURCE_FIELD 14:12
`define OSS_F_NEW_SOURCE_FIELD 10:8
`define OSS_B_LOCK 7
`define OSS_B_PLLOK 5
`define OSS_B_CF 3
`define OSS_B_DRV 2
`define OSS_B_SEN 1
`define OSS_B_SWEN 0
`define OSS_F_PSC 2:0
// ****************************************
// source codes and defaults
// ****************************************
`define OSS_SRC_FAST_RC_WITH_POSTSCALER 3'h7
`define OSS_SRC_LPFRC 3'h6
`define OSS_SRC_LOWPOWER_RC_SOURCE 3'h5
`define OSS_SRC_SECONDARY_SOURCE 3'h4
`define OSS_SRC_PPLL 3'h3
`define OSS_SRC_PRI 3'h2
`define OSS_SRC_FPLL 3'h1
`define OSS_SRC_FRC 3'h0
`define OSS_PM_HS 2'h2
`define OSS_PM_XT 2'h1
`define OSS_PM_EC 2'h0
`define OSS_SWM_ON 2'h0
`define OSS_EXT_RANGE_DFLT 2'h3
`define OSS_PSC_RST 3'h1
`define OSS_SWITCH_TICKS 10
`endif

// File: oss_pkg.sv
package oss_pkg;
  // configuration word latched at power-on
  typedef struct packed {
    logic [1:0] primary_mode_config;
    logic [2:0] initial_source_config;
    logic [1:0] switch_monitor_config;
    logic [1:0] ext_clock_range_config;
    logic secondary_power_config;
    logic secondary_input_source_config;
    logic osc_out_pin_function_config;
  } oss_cfg_s;
  // one-cycle edges of each raw oscillator, sampled on clk
  typedef struct packed {
    logic fast_rc;
    logic lowpower_fast_rc;
    logic lowpower_rc;
    logic secondary;
    logic primary;
    logic multiplier;
  } oss_ticks_s;
  typedef enum logic [3:0] {
    OSS_M_FAST_RC_WITH_POSTSCALER, OSS_M_LOWPOWER_FAST_RC_POSTSCALED, OSS_M_LOWPOWER_RC_SOURCE, OSS_M_SECONDARY_SOURCE, OSS_M_HIGHSPEED_CRYSTAL_MULTIPLIED_HS,
    OSS_M_EXTERNAL_CLOCK_MULTIPLIED_EC, OSS_M_HS, OSS_M_XT, OSS_M_EC, OSS_M_FAST_RC_WITH_MULTIPLIER, OSS_M_FRC,
    OSS_M_BAD
  } oss_mode_e;
  typedef enum logic [2:0] {
    OSS_IDLE = 3'b001,
    OSS_WAIT = 3'b010,
    OSS_SWAP = 3'b100
  } oss_state_e;
endpackage

// File: oss_osc_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// raw oscillator edges as seen from clk
// ****************************************
module oss_osc_model #(
  parameter int LOCK_AFTER = 40
) (
  // clock
  input wire logic clk,
  // oscillator side
  output oss_pkg::oss_ticks_s ticks,
  output logic pll_locked
);
  import oss_pkg::*;
  logic [7:0] cnt_r = 8'h00;
  logic lock_r = 1'b0;
  assign pll_locked = lock_r;
  // periods of 2, 5, 7, 9 and 3 cycles, multiplier in antiphase with fast RC
  always_ff @(posedge clk) begin
    cnt_r <= cnt_r + 8'h01;
    ticks <= '{(cnt_r % 2) == 0, (cnt_r % 5) == 0, (cnt_r % 7) == 0, (cnt_r % 9) == 0,
               (cnt_r % 3) == 0, (cnt_r % 2) == 1};
  end
  // multiplier lock comes late and then stays
  always_ff @(posedge clk) begin
    lock_r <= lock_r | (cnt_r == LOCK_AFTER[7:0]);
  end
endmodule // oss_osc_model
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import oss_pkg::*;
  typedef struct {logic [31:0] m; logic [31:0] v; logic e;} oss_exp_s;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic fail_detect = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd, lf;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, sys_tick, fcy, pin_o, pin_oe_n, pll_enable, sec_en, sec_hp, fsm_on;
  logic pll_locked, fp;
  logic [1:0] ext_range;
  oss_cfg_s cfg = '1;
  oss_ticks_s ticks;
  oss_mode_e mode;
  oss_exp_s q[$];
  oss_exp_s x;
  int mismatches = 0;
  int n_checks = 0;
  int k, nt, nf;
  logic [2:0] ti [11] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3, 3'h3, 3'h2, 3'h2, 3'h2, 3'h1, 3'h0};
  logic [1:0] tp [11] = '{2'h3, 2'h3, 2'h3, 2'h0, 2'h2, 2'h0, 2'h2, 2'h1, 2'h0, 2'h3, 2'h3};
  oss_mode_e tm [11] = '{OSS_M_FAST_RC_WITH_POSTSCALER, OSS_M_LOWPOWER_FAST_RC_POSTSCALED, OSS_M_LOWPOWER_RC_SOURCE, OSS_M_SECONDARY_SOURCE, OSS_M_HIGHSPEED_CRYSTAL_MULTIPLIED_HS,
    OSS_M_EXTERNAL_CLOCK_MULTIPLIED_EC, OSS_M_HS, OSS_M_XT, OSS_M_EC, OSS_M_FAST_RC_WITH_MULTIPLIER, OSS_M_FRC};
  always #2 clk = ~clk;
  oss_source_select i_oss_source_select (.clk(clk), .rstn(rstn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg), .ticks(ticks),
    .pll_locked(pll_locked), .fail_detect(fail_detect), .sys_tick(sys_tick), .fcy(fcy),
    .oscillator_output_pin_o(pin_o), .oscillator_output_pin_oe_n(pin_oe_n), .mode(mode),
    .pll_enable(pll_enable), .secondary_osc_enable(sec_en), .secondary_high_power(sec_hp),
    .ext_range(ext_range), .fail_safe_monitor(fsm_on));
  oss_osc_model i_oss_osc_model (.clk(clk), .ticks(ticks), .pll_locked(pll_locked));
  // ****************************************
  // compare, report, finish
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // ****************************************
  // apb master, expectation noted up front
  // ****************************************
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] m, input logic [31:0] v, input logic [3:0] s,
                     input logic e);
    int i;
    q.push_back('{m, v, e});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin
      mismatches++;
      wrap_up();
    end else begin
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] v,
                     input logic e);
    apb(1'b0, a, 32'h0, m, v, 4'h0, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    apb(1'b1, a, d, 32'h0, 32'h0, s, 1'b0);
  endtask
  task automatic rst(input logic [1:0] pm, input logic [2:0] ini, input logic [1:0] swm);
    rstn <= 1'b0;
    cfg <= '{pm, ini, swm, 2'h1, 1'b1, 1'b1, 1'b1};
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
  endtask
  // ****************************************
  // watcher: oldest note against each answer
  // ****************************************
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      if (q.size() == 0) chk("queue", 32'h1, 32'h0);
      else begin
        x = q.pop_front();
        chk("prdata", prdata & x.m, x.v);
        chk("pslverr", {31'h0, pslverr}, {31'h0, x.e});
      end
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    lf = 32'h1066;
    for (k = 0; k < 11; k++) begin
      rst(tp[k], ti[k], 2'h3);
      // lock status may be up only in multiplier modes
      rdc(12'h000, (ti[k] == 3 || ti[k] == 1) ? 32'hFFFF_FFDF : '1,
          {17'h0, ti[k], 1'b0, ti[k], 8'h00}, 1'b0);
      chk("mode", 32'(mode), 32'(tm[k]));
      chk("ext_range", 32'(ext_range), (tp[k] == 0 && ti[k][2:1] == 1) ? 32'h1 : 32'h3);
      chk("pll_enable", pll_enable, ti[k] == 3 || ti[k] == 1);
      chk("oe_n", pin_oe_n, ti[k][2:1] == 1 && tp[k] != 0);
      chk("monitor", fsm_on, 1'b0);
    end
    rst(2'h3, 3'h7, 2'h3);
    nt = 0;
    nf = 0;
    fp = fcy;
    repeat (200) begin
      @(posedge clk);
      nt += sys_tick;
      nf += (fcy !== fp);
      fp = fcy;
    end
    chk("fcy", nt > 0 && nf >= nt - 1 && nf <= nt + 1, 1'b1);
    chk("pin", pin_o, fcy);
    rdc(12'h004, '1, 32'h1, 1'b0);
    wr(12'h004, 32'h0, 4'h1);
    rdc(12'h004, '1, 32'h0, 1'b0);
    rdc(12'h008, '1, 32'h0, 1'b1);
    // switch disabled: start bit must read back zero
    repeat (4) begin
      lf = lfsr(lf);
      wr(12'h000, lf & 32'h7, 4'h1);
      rdc(12'h000, '1, 32'h7700 | (lf & 32'h6), 1'b0);
      chk("sec_en", sec_en, lf[1]);
      chk("sec_hp", sec_hp, 1'b1);
    end
    rst(2'h3, 3'h0, 2'h0);
    chk("monitor", fsm_on, 1'b1);
    wr(12'h000, 32'h0500, 4'h2);
    wr(12'h000, 32'h1, 4'h1);
    for (k = 0; k < 100 && rd[14:12] !== 3'h5; k++) rdc(12'h000, 32'h0, 32'h0, 1'b0);
    if (k == 100) begin
      mismatches++;
      wrap_up();
    end
    rdc(12'h000, '1, 32'h5500, 1'b0);
    chk("mode", 32'(mode), 32'(OSS_M_LOWPOWER_RC_SOURCE));
    wr(12'h000, 32'h1, 4'h1);
    rdc(12'h000, '1, 32'h5500, 1'b0);
    @(posedge clk);
    fail_detect <= 1'b1;
    @(posedge clk);
    fail_detect <= 1'b0;
    rdc(12'h000, '1, 32'h5508, 1'b0);
    wr(12'h000, 32'h0, 4'h1);
    rdc(12'h000, '1, 32'h5500, 1'b0);
    wr(12'h000, 32'h80, 4'h1);
    wr(12'h000, 32'h0700, 4'h2);
    wr(12'h000, 32'h0, 4'h1);
    rdc(12'h000, '1, 32'h5580, 1'b0);
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
